// ---- mcs_pkg.sv ----
`default_nettype none
package mcs_pkg;
   // Timebase
   localparam int CLK_PERIOD_NS = 4;
   localparam int CNT_W         = 10;

   // Register indices; byte address is four times the index
   localparam logic [9:0] REG_CTRL_IDX = 10'h0d1;
   localparam logic [9:0] REG_STAT_IDX = 10'h0d2;
   localparam int         ADDR_W       = 12;

   // Control register layout
   localparam int         OFF_BIT    = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status register layout
   localparam int ST_AUX  = 0;
   localparam int ST_MAIN = 1;
   localparam int ST_RUN  = 2;
   localparam int ST_SG   = 3;
   localparam int ST_RC   = 4;

   function automatic int ns_up(input int ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : ns_up

   function automatic int ns_down(input int ns);
      return ns / CLK_PERIOD_NS;
   endfunction : ns_down

   // Times in their own unit
   localparam int AUX_PERIOD_NS     = 2000;
   localparam int SG_MIN_PERIOD_NS  = 125;
   localparam int SPIKE_MIN_NS      = 20;
   localparam int MISS_TIMEOUT_NS   = 500;

   // Derived cycle counts
   localparam logic [CNT_W-1:0] AUX_CYC =
      CNT_W'(ns_down(AUX_PERIOD_NS));
   localparam logic [CNT_W-1:0] SG_MIN_CYC =
      CNT_W'(ns_up(SG_MIN_PERIOD_NS));
   localparam logic [CNT_W-1:0] SPIKE_CYC =
      CNT_W'(ns_up(SPIKE_MIN_NS));
   localparam logic [CNT_W-1:0] MISS_CYC =
      CNT_W'(ns_down(MISS_TIMEOUT_NS));

   // Good main edges needed before the main source is trusted
   localparam logic [6:0] START_EDGES_XTAL = 7'h40;
   localparam logic [6:0] START_EDGES_RC   = 7'h08;

   // Dividers and reset delay
   localparam logic [3:0] TIMER_DIV        = 4'hc;
   localparam logic [3:0] CORE_DIV         = 4'hd;
   localparam int         DELAY_SHORT_TICKS = 2048;
   localparam int         DELAY_LONG_TICKS  = 32768;

   typedef enum logic [0:0] {SRC_MAIN, SRC_AUX} mcs_src_t;

   function automatic logic [CNT_W-1:0] sat_inc(
      input logic [CNT_W-1:0] v);
      return (v == '1) ? v : v + CNT_W'(1);
   endfunction : sat_inc

   function automatic logic [9:0] reg_index(
      input logic [ADDR_W-1:0] addr);
      return addr[ADDR_W-1:2];
   endfunction : reg_index
endpackage : mcs_pkg
`default_nettype wire

// ---- mcs_tick_div.sv ----
`default_nettype none
module mcs_tick_div
   import mcs_pkg::*;
#(
   parameter logic [3:0] DIV = 4'h2
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Ticks
   input  wire logic in_tick,
   output var  logic tick
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
   } mcs_div_t;

   mcs_div_t s_r;
   mcs_div_t s_nxt;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (in_tick) begin
         if (s_r.cnt == DIV - 4'h1) begin
            s_nxt.cnt  = 4'h0;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = s_r.tick;
endmodule : mcs_tick_div
`default_nettype wire

// ---- mcs_clock_safeguard.sv ----
`default_nettype none
module mcs_clock_safeguard
   import mcs_pkg::*;
#(
   parameter int DLY_SHORT = DELAY_SHORT_TICKS,
   parameter int DLY_LONG  = DELAY_LONG_TICKS
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Option straps
   input  wire logic              safeguard_enable_option,
   input  wire logic              osc_type_option,
   input  wire logic              delay_option,
   // Main oscillator
   input  wire logic              osc_in,
   output var  logic              main_osc_en,
   // Clock and reset outputs
   output var  logic              int_clk_tick,
   output var  logic              timer_clk_tick,
   output var  logic              core_clk_tick,
   output var  logic              aux_low_freq_osc,
   output var  logic              cpu_rst_n
);
   typedef struct packed {
      logic             opt_done;
      logic             sg;
      logic             rc;
      logic             dly_long;
      logic [7:0]       ctrl;
      logic             osc_q;
      logic [CNT_W-1:0] stab;
      logic             lvl;
      logic [CNT_W-1:0] gap;
      logic [CNT_W-1:0] miss;
      logic [6:0]       good;
      logic             main_ok;
      mcs_src_t         src;
      logic             aux_on;
      logic [CNT_W-1:0] aux_cnt;
      logic [CNT_W-1:0] tgap;
      logic             sw_hold;
      logic [15:0]      dly;
      logic             run;
      logic             tick;
      logic             osc_en;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic [3:0]       hc12;
      logic [3:0]       hc13;
   } mcs_state_t;

   mcs_state_t s_r;
   mcs_state_t s_nxt;

   logic        edge_seen;
   logic        acc_edge;
   logic        lost;
   logic        aux_tick;
   logic        cand;
   logic [6:0]  good_target;
   logic [15:0] dly_last;
   logic [9:0]  idx;
   logic        wr_ctrl;
   logic        timer_tick_w;
   logic        core_tick_w;

   always_comb begin
      s_nxt         = s_r;
      s_nxt.tick    = 1'b0;
      s_nxt.pready  = 1'b0;
      s_nxt.pslverr = 1'b0;
      idx           = reg_index(paddr);
      wr_ctrl       = 1'b0;

      // Straps are caught once, just after reset release
      if (!s_r.opt_done) begin
         s_nxt.opt_done = 1'b1;
         s_nxt.sg       = safeguard_enable_option;
         s_nxt.rc       = osc_type_option;
         s_nxt.dly_long = delay_option;
         // Power-on delay runs from the auxiliary source until the main source is trusted
         if (safeguard_enable_option) begin
            s_nxt.src = SRC_AUX;
         end
      end

      // Spike filter: level accepted only after it stays stable
      s_nxt.osc_q = osc_in;
      s_nxt.stab  = (osc_in == s_r.osc_q) ? sat_inc(s_r.stab)
                                          : '0;
      if (!s_r.sg || s_r.stab >= SPIKE_CYC) begin
         s_nxt.lvl = s_r.osc_q;
      end
      edge_seen = s_nxt.lvl && !s_r.lvl && s_r.osc_en;
      // Frequency cap: edges closer than the minimum are dropped
      acc_edge  = edge_seen &&
                  (!s_r.sg || s_r.gap >= SG_MIN_CYC - CNT_W'(1));
      s_nxt.gap  = acc_edge ? '0 : sat_inc(s_r.gap);
      s_nxt.miss = edge_seen ? '0 : sat_inc(s_r.miss);
      lost       = (s_r.miss >= MISS_CYC) || !s_r.osc_en;

      // Main oscillator trusted after enough good edges
      good_target = s_r.rc ? START_EDGES_RC : START_EDGES_XTAL;
      if (lost) begin
         s_nxt.good = 7'h00;
      end else if (acc_edge && s_r.good != good_target) begin
         s_nxt.good = s_r.good + 7'h01;
      end
      s_nxt.main_ok = (s_nxt.good == good_target);

      // Main oscillator enable follows the off bit while the safeguard is on
      s_nxt.osc_en = !(s_r.ctrl[OFF_BIT] && s_r.sg);

      // Source selection
      unique case (s_r.src)
         SRC_MAIN: begin
            if (s_r.sg && lost) begin
               s_nxt.src     = SRC_AUX;
               s_nxt.aux_cnt = '0;
               s_nxt.sw_hold = 1'b1;
            end
         end
         SRC_AUX: begin
            if (s_r.main_ok) begin
               s_nxt.src     = SRC_MAIN;
               s_nxt.sw_hold = 1'b1;
            end
         end
      endcase
      s_nxt.aux_on = (s_nxt.src == SRC_AUX);

      // Auxiliary oscillator: first tick one period after start
      aux_tick = 1'b0;
      if (s_r.aux_on) begin
         if (s_r.aux_cnt == AUX_CYC - CNT_W'(1)) begin
            s_nxt.aux_cnt = '0;
            aux_tick      = 1'b1;
         end else begin
            s_nxt.aux_cnt = s_r.aux_cnt + CNT_W'(1);
         end
      end

      // Internal clock; after a switch the gap is held open
      cand = (s_r.src == SRC_AUX) ? aux_tick : acc_edge;
      if (cand && (!s_r.sw_hold ||
                   s_r.tgap >= SG_MIN_CYC - CNT_W'(1))) begin
         s_nxt.tick    = 1'b1;
         // A switch in this very cycle keeps the hold armed
         s_nxt.sw_hold = (s_nxt.src != s_r.src);
      end
      s_nxt.tgap = s_nxt.tick ? '0 : sat_inc(s_r.tgap);

      // Reset delay counted on the internal clock, whatever its source
      dly_last = s_r.dly_long ? 16'(DLY_LONG - 1)
                              : 16'(DLY_SHORT - 1);
      if (s_r.tick && !s_r.run && s_r.opt_done) begin
         if (s_r.dly == dly_last) begin
            s_nxt.run = 1'b1;
         end else begin
            s_nxt.dly = s_r.dly + 16'h0001;
         end
      end

      // APB setup phase: answer prepared, ready in access phase
      if (psel && !penable) begin
         s_nxt.pready = 1'b1;
         s_nxt.prdata = 32'h0000_0000;
         if (idx == REG_CTRL_IDX) begin
            s_nxt.prdata = {24'h00_0000, s_r.ctrl};
         end else if (idx == REG_STAT_IDX && !pwrite) begin
            s_nxt.prdata[ST_AUX]  = s_r.aux_on;
            s_nxt.prdata[ST_MAIN] = s_r.main_ok;
            s_nxt.prdata[ST_RUN]  = s_r.run;
            s_nxt.prdata[ST_SG]   = s_r.sg;
            s_nxt.prdata[ST_RC]   = s_r.rc;
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      // Write takes effect at the completing edge
      if (psel && penable && s_r.pready && pwrite &&
          idx == REG_CTRL_IDX) begin
         wr_ctrl    = 1'b1;
         s_nxt.ctrl = pwdata[7:0];
      end

      // Assertion helpers: internal ticks per divided tick
      s_nxt.hc12 = timer_tick_w ? {3'h0, s_r.tick}
                 : (s_r.tick ? s_r.hc12 + 4'h1 : s_r.hc12);
      s_nxt.hc13 = core_tick_w ? {3'h0, s_r.tick}
                 : (s_r.tick ? s_r.hc13 + 4'h1 : s_r.hc13);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r      <= '0;
         s_r.ctrl <= CTRL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Timer, converter and watchdog clock
   mcs_tick_div #(
      .DIV (TIMER_DIV)
   ) u_timer_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_tick (s_r.tick),
      .tick    (timer_tick_w)
   );

   // Core machine-cycle clock; instructions take 2, 4 or 5 of these
   mcs_tick_div #(
      .DIV (CORE_DIV)
   ) u_core_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_tick (s_r.tick),
      .tick    (core_tick_w)
   );

   assign prdata           = s_r.prdata;
   assign pready           = s_r.pready;
   assign pslverr          = s_r.pslverr;
   assign main_osc_en      = s_r.osc_en;
   assign int_clk_tick     = s_r.tick;
   assign timer_clk_tick   = timer_tick_w;
   assign core_clk_tick    = core_tick_w;
   assign aux_low_freq_osc = s_r.aux_on;
   assign cpu_rst_n        = s_r.run;

   localparam int A_AUX_LO = int'(AUX_CYC) - 1;
   localparam int A_AUX_HI = int'(AUX_CYC) + 1;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_timer_div12: assert property (
      timer_tick_w |-> s_r.hc12 == TIMER_DIV)
      else $error("timer tick not every 12 internal ticks");

   a_core_div13: assert property (
      core_tick_w |-> s_r.hc13 == CORE_DIV)
      else $error("core tick not every 13 internal ticks");

   a_osc_off_stop: assert property (
      (s_r.ctrl[OFF_BIT] && s_r.sg) |=> !s_r.osc_en)
      else $error("main oscillator not stopped");

   a_osc_restart: assert property (
      (s_r.opt_done && !s_r.ctrl[OFF_BIT]) |=> s_r.osc_en)
      else $error("main oscillator not restarted");

   a_aux_needs_sg: assert property (
      s_r.aux_on |-> s_r.sg)
      else $error("auxiliary running without safeguard");

   a_aux_first_tick: assert property (
      $rose(s_r.aux_on) |-> ##[A_AUX_LO:A_AUX_HI] s_r.tick)
      else $error("auxiliary first tick mistimed");

   a_aux_off_main: assert property (
      (s_r.src == SRC_AUX && s_r.main_ok) |=> !s_r.aux_on)
      else $error("auxiliary not stopped when main runs");

   a_tick_spacing: assert property (
      (s_r.sg && s_r.tick) |->
         $past(s_r.tgap) >= SG_MIN_CYC - CNT_W'(1))
      else $error("internal clock above safeguard limit");

   a_spike_block: assert property (
      (s_r.sg && edge_seen) |-> s_r.stab >= SPIKE_CYC)
      else $error("unfiltered spike produced an edge");

   a_delay_release: assert property (
      $rose(s_r.run) |-> $past(s_r.tick) &&
                         $past(s_r.dly) == $past(dly_last))
      else $error("reset delay released early");

   a_ctrl_write: assert property (
      wr_ctrl |=> {24'h00_0000, s_r.ctrl} ==
                  ($past(pwdata) & 32'h0000_00ff))
      else $error("control write lost");

   a_apb_ready: assert property (
      (psel && !penable) |=> s_r.pready)
      else $error("no ready in access phase");

   a_aux_power_on: assert property (
      (!s_r.opt_done && safeguard_enable_option) |-> ##2 s_r.aux_on)
      else $error("power-on delay not on auxiliary clock");

   a_osc_on_unguarded: assert property (
      (s_r.opt_done && !s_r.sg) |=> s_r.osc_en)
      else $error("main oscillator stopped without safeguard");

   a_ctrl_stable: assert property (
      !wr_ctrl |=> $stable(s_r.ctrl))
      else $error("control register changed without a write");

   a_pready_pulse: assert property (
      s_r.pready |=> !s_r.pready)
      else $error("ready held longer than one cycle");

   a_err_no_write: assert property (
      (s_r.pready && s_r.pslverr) |-> !wr_ctrl)
      else $error("refused transfer changed the control register");

   c_aux_start: cover property ($rose(s_r.aux_on));
   c_main_return: cover property ($fell(s_r.aux_on));
   c_cpu_release: cover property ($rose(s_r.run));
   c_osc_off_write: cover property (wr_ctrl && pwdata[OFF_BIT]);
endmodule : mcs_clock_safeguard
`default_nettype wire

// ---- mcs_osc_model.sv ----
`default_nettype none
module mcs_osc_model
   import mcs_pkg::*;
#(
   parameter int STARTUP = 16
) (
   // Clock
   input  wire logic       pclk,
   // Control from device and bench
   input  wire logic       main_osc_en,
   input  wire logic       stopped,
   input  wire logic       spike,
   input  wire logic [7:0] half,
   // Oscillator line
   output var  logic       osc_in
);
   timeunit 1ns;
   timeprecision 100ps;

   int wake;
   int ph;

   initial begin
      osc_in = 1'b0;
      wake = STARTUP;
      ph = 0;
   end

   // A stopped or disabled oscillator holds its line low
   always @(posedge pclk) begin
      if (!main_osc_en || stopped) begin
         wake <= STARTUP;
         ph <= 0;
         osc_in <= 1'b0;
      end else if (wake > 0) begin
         wake <= wake - 1;
      end else begin
         ph <= (ph + 1) % (2 * int'(half));
         // Optional two-cycle spikes inside the low phase
         osc_in <= (ph < int'(half)) ||
                   (spike && ph >= int'(half) + 4 && ph < int'(half) + 6);
      end
   end
endmodule : mcs_osc_model
`default_nettype wire

// ---- mcu_clock_safeguard_bench.sv ----
`default_nettype none
module mcu_clock_safeguard_bench
   import mcs_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int DS = 4;
   localparam int DL = 8;

   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic              sg, rc, dly, osc_in, stopped, spike, main_osc_en;
   logic              int_t, tmr_t, core_t, aux, cpu_rst_n;
   logic [7:0]        half, d;
   logic [33:0]       expq[$];
   logic [33:0]       e;
   int                n_fail, comparisons, seed, n_int, n_pre, k;
   int                tcnt, ccnt, gap;
   bit                tfirst, cfirst;

   mcs_clock_safeguard #(.DLY_SHORT(DS), .DLY_LONG(DL)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .safeguard_enable_option(sg), .osc_type_option(rc),
      .delay_option(dly), .osc_in(osc_in), .main_osc_en(main_osc_en),
      .int_clk_tick(int_t), .timer_clk_tick(tmr_t),
      .core_clk_tick(core_t), .aux_low_freq_osc(aux),
      .cpu_rst_n(cpu_rst_n));

   mcs_osc_model u_osc (
      .pclk(pclk), .main_osc_en(main_osc_en), .stopped(stopped),
      .spike(spike), .half(half), .osc_in(osc_in));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic tally_and_finish;
      if (n_fail == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic check(input string nm, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : check

   task automatic wait_lvl(input int sel, input logic lvl, input int bound,
                           input string nm);
      int   i;
      logic v;
      for (i = 0; i < bound; i++) begin
         @(posedge pclk);
         v = (sel == 0) ? aux : (sel == 1) ? main_osc_en : cpu_rst_n;
         if (v === lvl) break;
      end
      check(nm, 32'(lvl), 32'(v));
      if (i == bound) tally_and_finish();
   endtask : wait_lvl

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic wr, input logic [9:0] idx,
                      input logic [7:0] wd, input logic err,
                      input logic [7:0] exp);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'($random(seed)), wd};
      expq.push_back({wr, err, 24'h000000, exp});
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         check("pready", 32'h1, 32'h0);
         tally_and_finish();
      end
   endtask : apb

   task automatic do_reset(input logic s, input logic r, input logic dl);
      presetn <= 1'b0;
      sg <= s;
      rc <= r;
      dly <= dl;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   // Response monitor
   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         if (expq.size() == 0) begin
            check("apb_answer", 32'h0, 32'h1);
         end else begin
            e = expq.pop_front();
            check("pslverr", 32'(e[32]), 32'(pslverr));
            if (!e[33]) check("prdata", e[31:0], prdata);
         end
      end
   end

   // Tick monitor
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcnt = 0;
         ccnt = 0;
         gap = 0;
         n_pre = 0;
         tfirst = 1'b0;
         cfirst = 1'b0;
      end else begin
         if (tmr_t === 1'b1) begin
            if (tfirst) check("timer_div", 32'd12, 32'(tcnt));
            tfirst = 1'b1;
            tcnt = int'(int_t);
         end else tcnt += int'(int_t);
         if (core_t === 1'b1) begin
            if (cfirst) check("core_div", 32'd13, 32'(ccnt));
            cfirst = 1'b1;
            ccnt = int'(int_t);
         end else ccnt += int'(int_t);
         if (int_t === 1'b1) begin
            if (sg && gap > 0 && gap < int'(SG_MIN_CYC))
               check("tick_gap", 32'(SG_MIN_CYC), 32'(gap));
            gap = 1;
         end else if (gap > 0) gap++;
         n_int += int'(int_t);
         if (!cpu_rst_n) n_pre += int'(int_t);
      end
   end

   initial begin
      seed = 25;
      {n_fail, comparisons, n_int} = '0;
      {presetn, psel, penable, pwrite, rc, dly, stopped, spike} = '0;
      sg = 1'b1;
      paddr = '0;
      pwdata = '0;
      half = 8'h14;
      @(posedge pclk);
      do_reset(1'b1, 1'b0, 1'b0);
      wait_lvl(2, 1'b1, 40000, "cpu_rst_n");
      check("delay_ticks", 32'(DS), 32'(n_pre));
      wait_lvl(0, 1'b0, 20000, "aux_off");
      apb(1'b0, REG_STAT_IDX, 8'h00, 1'b0, 8'h0e);
      apb(1'b0, REG_CTRL_IDX, 8'h00, 1'b0, CTRL_RESET);
      d = 8'($random(seed)) & 8'hfb;
      apb(1'b1, REG_CTRL_IDX, d, 1'b0, 8'h00);
      apb(1'b0, REG_CTRL_IDX, 8'h00, 1'b0, d);
      check("main_osc_en", 32'h1, 32'(main_osc_en));
      apb(1'b0, 10'h000, 8'h00, 1'b1, 8'h00);
      apb(1'b1, REG_STAT_IDX, 8'hff, 1'b1, 8'h00);
      apb(1'b1, REG_CTRL_IDX, 8'h04, 1'b0, 8'h00);
      wait_lvl(1, 1'b0, 4, "main_off");
      wait_lvl(0, 1'b1, 4, "aux_on");
      k = n_int;
      repeat (int'(AUX_CYC) - 20) @(posedge pclk);
      check("aux_first_tick", 32'(k), 32'(n_int));
      apb(1'b0, REG_STAT_IDX, 8'h00, 1'b0, 8'h0d);
      apb(1'b1, REG_CTRL_IDX, 8'h00, 1'b0, 8'h00);
      wait_lvl(1, 1'b1, 4, "main_on");
      wait_lvl(0, 1'b0, 8000, "aux_off");
      // Over-frequency: the gap monitor watches the tick spacing
      half <= 8'h06;
      repeat (2000) @(posedge pclk);
      half <= 8'h14;
      wait_lvl(0, 1'b0, 8000, "aux_off");
      // A slow main clock puts spikes past the frequency cap; only the spike filter keeps them out of the tick count
      half <= 8'h28;
      spike <= 1'b1;
      k = n_int;
      repeat (2000) @(posedge pclk);
      spike <= 1'b0;
      half <= 8'h14;
      check("spike_ticks", 32'h1, 32'(n_int - k inside {[23:27]}));
      stopped <= 1'b1;
      wait_lvl(0, 1'b1, 200, "aux_on_miss");
      stopped <= 1'b0;
      wait_lvl(0, 1'b0, 8000, "aux_off");
      do_reset(1'b0, 1'b1, 1'b1);
      wait_lvl(2, 1'b1, 4000, "cpu_rst_n");
      check("delay_ticks", 32'(DL), 32'(n_pre));
      apb(1'b0, REG_STAT_IDX, 8'h00, 1'b0, 8'h16);
      apb(1'b1, REG_CTRL_IDX, 8'h04, 1'b0, 8'h00);
      repeat (10) @(posedge pclk);
      check("main_osc_en", 32'h1, 32'(main_osc_en));
      stopped <= 1'b1;
      repeat (300) @(posedge pclk);
      check("aux_no_sg", 32'h0, 32'(aux));
      stopped <= 1'b0;
      tally_and_finish();
   end
endmodule : mcu_clock_safeguard_bench
`default_nettype wire
